// ===== inc/prl_consts.svh
// Purpose: Offsets, field positions, reset values for the pin remap unit
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes: Definitions only
`ifndef PRL_CONSTS_SVH
`define PRL_CONSTS_SVH
`define PRL_NUM_IN 8
`define PRL_NUM_PIN 16
`define PRL_NUM_OUT_SRC 8
`define PRL_CODE_W 6
`define PRL_LOCK_OFS 12'h000
`define PRL_CFG_OFS 12'h004
`define PRL_IN_BASE 12'h100
`define PRL_OUT_BASE 12'h200
`define PRL_LOCK_BIT 0
`define PRL_ONESHOT_BIT 0
`define PRL_KEY1 8'h55
`define PRL_KEY2 8'haa
`define PRL_IN_DEFAULTS 64'h07_06_05_04_03_02_01_00
`define PRL_OUT_RESET 6'h00
`define PRL_LATCH_CODE 6'h00
`endif

// ===== inc/prl_pkg.sv
// Purpose: Types shared by the pin remap unit
// Assumes: Constants come from prl_consts.svh
// Notes: Types only
package prl_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT1,
    KEY_ARMED
  } key_type;
  typedef enum logic [1:0] {
    ONE_FRESH,
    ONE_CLEARED,
    ONE_SPENT
  } oneshot_type;
endpackage : prl_pkg

// ===== src/prl_sel_reg.sv
// Purpose: One six-bit selection register with an async power-on reset only
// Assumes: Power-on reset async; system reset sync and keeps contents
// Notes: Used for input and output selections
`timescale 1ns/1ns
`default_nettype none
module prl_sel_reg #(
  parameter logic [5:0] DEF = 6'h00
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [5:0] wdata,
  // Stored code
  output logic [5:0] q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= DEF;
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule : prl_sel_reg
`default_nettype wire

// ===== src/prl_pin_mux.sv
// Purpose: Output mux for one pin: latch or selected peripheral
// Assumes: Code 0 means port latch; code n in 1..8 picks peripheral n-1
// Notes: Pure combinational, registered by the caller
`include "prl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module prl_pin_mux (
  // Selection and sources
  input wire logic [5:0] code,
  input wire logic latch_bit,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  input wire logic dir_in,
  // Pin result
  output logic pin_val,
  output logic pin_oe_n
);
  wire logic use_latch;
  wire logic in_range;
  wire logic [2:0] idx;
  assign use_latch = (code == `PRL_LATCH_CODE);
  assign in_range = (code <= 6'd8);
  assign idx = 3'(code - 6'd1);
  // Unrouted codes fall back to latch so the pin never floats undefined
  assign pin_val = (use_latch || !in_range) ? latch_bit : periph_out[idx];
  // Routed peripheral sets direction from its own enable, ignoring dir_in
  assign pin_oe_n = (use_latch || !in_range) ? dir_in
                                             : ~periph_oe[idx];
endmodule : prl_pin_mux
`default_nettype wire

// ===== src/prl_remap_top.sv
// Purpose: Pin remap unit with lockable input and output selections
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: RSTN is power-on/brown-out reset; SYS_RSTN is any other reset
// Contract
// - One selection register per input function
// - Bits 5..0 name the input pin; the pin pick uses bits 3..0 only
// - Input select bits 7..6 read zero
// - Input defaults on power reset only
// - Interrupt codes 0..15 pick first sixteen pins
// - Per pin output select, six bit code
// - Output selects zero on power reset only
// - Routed peripheral may override pin direction
// - Lock bit freezes selections, resets always
// - Lock register bits 7..1 read zero
// - One-shot option: one clear, one set
// - Power reset restores selection defaults
// - Output code zero drives port latch
`include "prl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module prl_remap_top (
  // Clock and resets
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SYS_RSTN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Configuration
  input wire logic ONE_SHOT_LOCK_OPTION,
  // Pins
  input wire logic [15:0] PIN_IN,
  input wire logic [15:0] PORT_LATCH_BIT,
  input wire logic [15:0] PIN_DIRECTION_CONTROL,
  output logic [15:0] PIN_OUT,
  output logic [15:0] PIN_OE_N,
  // Peripherals
  output logic [7:0] PERIPH_IN,
  input wire logic [7:0] PERIPH_OUT,
  input wire logic [7:0] PERIPH_OE,
  // Status
  output logic SELECTIONS_FROZEN
);
  // Address phase capture
  logic wr_pend_r;
  logic [11:0] addr_r;
  logic lock_r;
  logic [31:0] rdata_r;
  prl_pkg::key_type key_r;
  prl_pkg::key_type key_nxt;
  prl_pkg::oneshot_type one_r;
  prl_pkg::oneshot_type one_nxt;
  wire logic take;
  wire logic [7:0] wbyte;
  wire logic lock_hit;
  wire logic in_hit;
  wire logic out_hit;
  wire logic [2:0] in_idx;
  wire logic [3:0] out_idx;
  wire logic sel_we;
  wire logic key1;
  wire logic key2;
  wire logic lock_cmd;
  wire logic lock_ok;
  wire logic lock_nxt;
  wire logic [5:0] in_sel [`PRL_NUM_IN];
  wire logic [5:0] out_sel [`PRL_NUM_PIN];
  wire logic [15:0] mux_val;
  wire logic [15:0] mux_oe_n;
  wire logic [11:0] raddr;
  wire logic [31:0] rdata_nxt;
  wire logic [7:0] in_pick;
  wire logic frozen_nxt;
  // One byte per input function, low six bits used as the default code
  localparam logic [63:0] IN_DEFS = `PRL_IN_DEFAULTS;

  assign take = HSEL && HREADY && HTRANS[1];
  assign wbyte = HWDATA[7:0];
  assign lock_hit = (addr_r == `PRL_LOCK_OFS);
  assign in_hit = (addr_r[11:8] == 4'(`PRL_IN_BASE >> 8)) &&
                  (addr_r[7:5] == 3'd0) && (addr_r[1:0] == 2'd0);
  assign out_hit = (addr_r[11:8] == 4'(`PRL_OUT_BASE >> 8)) &&
                   (addr_r[7:6] == 2'd0) && (addr_r[1:0] == 2'd0);
  assign in_idx = addr_r[4:2];
  assign out_idx = addr_r[5:2];
  // Frozen selections drop every write to the select banks
  assign sel_we = wr_pend_r && !lock_r;
  // Unlock key sequence decode
  assign key1 = wr_pend_r && lock_hit && (wbyte == `PRL_KEY1);
  assign key2 = wr_pend_r && lock_hit && (wbyte == `PRL_KEY2);
  assign lock_cmd = wr_pend_r && lock_hit && (key_r == prl_pkg::KEY_ARMED);
  // One-shot option allows a single clear and a single set per reset
  assign lock_ok = !ONE_SHOT_LOCK_OPTION ||
                   (wbyte[`PRL_LOCK_BIT] ? one_r != prl_pkg::ONE_SPENT
                                         : one_r == prl_pkg::ONE_FRESH);
  assign lock_nxt = (lock_cmd && lock_ok) ? wbyte[`PRL_LOCK_BIT] : lock_r;
  // Status must drop with the lock on a system reset, not a cycle later
  assign frozen_nxt = SYS_RSTN && lock_nxt;

  always_comb begin
    key_nxt = key_r;
    if (wr_pend_r) begin
      // Any write other than the next key or a repeated first key aborts the sequence
      case (key_r)
        prl_pkg::KEY_IDLE: key_nxt = key1 ? prl_pkg::KEY_GOT1
                                          : prl_pkg::KEY_IDLE;
        prl_pkg::KEY_GOT1: key_nxt = key2 ? prl_pkg::KEY_ARMED
                                          : (key1 ? prl_pkg::KEY_GOT1
                                                  : prl_pkg::KEY_IDLE);
        prl_pkg::KEY_ARMED: key_nxt = prl_pkg::KEY_IDLE;
        default: key_nxt = prl_pkg::KEY_IDLE;
      endcase
    end
  end

  always_comb begin
    one_nxt = one_r;
    case (one_r)
      prl_pkg::ONE_FRESH: if (lock_cmd && !wbyte[0]) begin
        one_nxt = prl_pkg::ONE_CLEARED;
      end else if (lock_cmd && wbyte[0]) begin
        one_nxt = prl_pkg::ONE_SPENT;
      end
      prl_pkg::ONE_CLEARED: if (lock_cmd && wbyte[0]) begin
        one_nxt = prl_pkg::ONE_SPENT;
      end
      prl_pkg::ONE_SPENT: one_nxt = prl_pkg::ONE_SPENT;
      default: one_nxt = prl_pkg::ONE_FRESH;
    endcase
  end

  // Lock and key state reset on every reset kind
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_r <= 1'b0;
      key_r <= prl_pkg::KEY_IDLE;
      one_r <= prl_pkg::ONE_FRESH;
    end else if (!SYS_RSTN) begin
      lock_r <= 1'b0;
      key_r <= prl_pkg::KEY_IDLE;
      one_r <= prl_pkg::ONE_FRESH;
    end else begin
      lock_r <= lock_nxt;
      key_r <= key_nxt;
      one_r <= one_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      wr_pend_r <= take && HWRITE;
      addr_r <= take ? HADDR : addr_r;
    end
  end

  // Selection banks hold through system reset, default on power reset
  genvar g;
  generate
    for (g = 0; g < `PRL_NUM_IN; g++) begin : g_in
      // Each input function owns its own selection register
      prl_sel_reg #(
        .DEF(IN_DEFS[8*g +: 6])
      ) u_in (
        .clk(CLK),
        .rst_n(RSTN),
        .we(sel_we && in_hit && in_idx == 3'(g)),
        .wdata(wbyte[5:0]),
        .q(in_sel[g])
      );
      // Codes 0..15 map onto the sixteen pins in order
      assign in_pick[g] = PIN_IN[in_sel[g][3:0]];
    end
    for (g = 0; g < `PRL_NUM_PIN; g++) begin : g_out
      prl_sel_reg #(
        .DEF(`PRL_OUT_RESET)
      ) u_out (
        .clk(CLK),
        .rst_n(RSTN),
        .we(sel_we && out_hit && out_idx == 4'(g)),
        .wdata(wbyte[5:0]),
        .q(out_sel[g])
      );
      prl_pin_mux u_mux (
        .code(out_sel[g]),
        .latch_bit(PORT_LATCH_BIT[g]),
        .periph_out(PERIPH_OUT),
        .periph_oe(PERIPH_OE),
        .dir_in(PIN_DIRECTION_CONTROL[g]),
        .pin_val(mux_val[g]),
        .pin_oe_n(mux_oe_n[g])
      );
    end
  endgenerate

  // Read mux; unimplemented upper bits read zero
  assign raddr = take ? HADDR : 12'hfff;
  assign rdata_nxt =
    (raddr == `PRL_LOCK_OFS) ? {31'd0, lock_r} :
    (raddr == `PRL_CFG_OFS) ? {31'd0, ONE_SHOT_LOCK_OPTION} :
    (raddr[11:8] == 4'h1 && raddr[7:5] == 3'd0) ?
      {26'd0, in_sel[raddr[4:2]]} :
    (raddr[11:8] == 4'h2 && raddr[7:6] == 2'd0) ?
      {26'd0, out_sel[raddr[5:2]]} : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= 32'h0000_0000;
      PIN_OUT <= 16'h0000;
      PIN_OE_N <= 16'hffff;
      PERIPH_IN <= 8'h00;
      SELECTIONS_FROZEN <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      PIN_OUT <= mux_val;
      PIN_OE_N <= mux_oe_n;
      PERIPH_IN <= in_pick;
      SELECTIONS_FROZEN <= frozen_nxt;
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Idle cycles may separate the keys, so each step is checked on its own
  sequence key_first_s;
    key1 && key_r == prl_pkg::KEY_IDLE;
  endsequence
  sequence key_second_s;
    key2 && key_r == prl_pkg::KEY_GOT1;
  endsequence

  locked_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (lock_r && wr_pend_r && out_hit && out_idx == 4'd1)
      |=> $stable(out_sel[1]))
    else $error("Output select changed while locked");
  lock_needs_key_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(SYS_RSTN) && $changed(lock_r))
      |-> $past(key_r) == prl_pkg::KEY_ARMED)
    else $error("Lock changed without unlock keys");
  oneshot_spent_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (ONE_SHOT_LOCK_OPTION && one_r == prl_pkg::ONE_SPENT && SYS_RSTN)
      |=> lock_r)
    else $error("One-shot lock released");
  latch_pass_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (out_sel[1] == 6'h00) |=> PIN_OUT[1] == $past(PORT_LATCH_BIT[1]))
    else $error("Zero code did not pass latch");
  lock_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(take) && $past(HADDR) == `PRL_LOCK_OFS)
      |-> HRDATA[31:1] == 31'd0)
    else $error("Lock upper bits not zero");
  in_route_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (in_sel[0] < 6'h10) |=>
      PERIPH_IN[0] == 1'($past(PIN_IN) >> $past(in_sel[0])))
    else $error("Input routing wrong");
  unlock_arm_a: assert property (@(posedge CLK) disable iff (!RSTN || !SYS_RSTN)
    key_second_s |=> key_r == prl_pkg::KEY_ARMED)
    else $error("Keys did not arm lock write");
  key_first_a: assert property (@(posedge CLK) disable iff (!RSTN || !SYS_RSTN)
    key_first_s |=> key_r == prl_pkg::KEY_GOT1)
    else $error("First key not taken");
  sys_reset_lock_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !SYS_RSTN |=> !lock_r && !SELECTIONS_FROZEN)
    else $error("Lock survived reset");
endmodule : prl_remap_top
`default_nettype wire

// ===== tb/prl_pin_env.sv
// Purpose: Pins and peripherals around the pin remap unit
// Assumes: Undriven pins follow an external pattern, never the last value
// Notes: Peripheral outputs are fixed so expectations stay simple
`timescale 1ns/1ns
`default_nettype none
module prl_pin_env #(
  parameter logic [15:0] EXT = 16'ha5c3,
  parameter logic [7:0] POUT = 8'h3c,
  parameter logic [7:0] POE = 8'h0f
) (
  // Pin side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  output logic [15:0] pin_in,
  // Peripheral side
  output logic [7:0] periph_out,
  output logic [7:0] periph_oe
);
  // A released pin shows the outside level, so stale data cannot pass
  assign pin_in = (pin_out & ~pin_oe_n) | (EXT & pin_oe_n);
  assign periph_out = POUT;
  assign periph_oe = POE;
endmodule : prl_pin_env
`default_nettype wire

// ===== tb/prl_remap_top_tb.sv
// Purpose: Self-checking bench for the pin remap unit
// Assumes: Zero wait AHB-Lite slave, one register per word
// Notes: Only byte 0 carries data
`timescale 1ns/1ns
`default_nettype none
`include "prl_consts.svh"
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error %s exp %h got %h", n, e, g); \
  end \
end
module prl_remap_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sys_rstn = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic opt = 1'b0;
  logic [15:0] latch = 16'h5a5b;
  logic [15:0] dir = 16'hfffe;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe_n;
  logic [7:0] p_in;
  logic [7:0] p_out;
  logic [7:0] p_oe;
  logic frozen;
  int err_count = 0;
  int checks_done = 0;
  localparam logic [15:0] EXT = 16'ha5c3;
  prl_remap_top uut (.CLK(clk), .RSTN(rstn), .SYS_RSTN(sys_rstn),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ONE_SHOT_LOCK_OPTION(opt),
    .PIN_IN(pin_in), .PORT_LATCH_BIT(latch), .PIN_DIRECTION_CONTROL(dir),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PERIPH_IN(p_in),
    .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .SELECTIONS_FROZEN(frozen));
  prl_pin_env #(.EXT(EXT)) env (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .periph_out(p_out), .periph_oe(p_oe));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
    `CHK("hresp", 1'b0, hresp)
    `CHK("rd upper", 24'h000000, hrdata[31:8])
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e,
    input string n);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    `CHK(n, e, q)
  endtask : chk_rd
  // Software keeps the key order and writes nothing in between
  task automatic unlock(input logic [7:0] v);
    wr(`PRL_LOCK_OFS, `PRL_KEY1);
    wr(`PRL_LOCK_OFS, `PRL_KEY2);
    wr(`PRL_LOCK_OFS, v);
  endtask : unlock
  task automatic por;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : por
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_rd(`PRL_LOCK_OFS, 8'h00, "lock reset");
    for (int k = 0; k < 8; k++) begin
      chk_rd(`PRL_IN_BASE + 12'(4 * k), 8'(k), "in default");
    end
    for (int p = 0; p < 16; p++) begin
      chk_rd(`PRL_OUT_BASE + 12'(4 * p), 8'h00, "out default");
    end
    chk_rd(12'h080, 8'h00, "unmapped");
    wr(`PRL_IN_BASE + 12'h004, 8'hc5);
    chk_rd(`PRL_IN_BASE + 12'h004, 8'h05, "in bits");
    // Interrupt input stays within the first sixteen pins
    wr(`PRL_IN_BASE, 8'h0f);
    wr(`PRL_OUT_BASE + 12'h004, 8'hc3);
    chk_rd(`PRL_OUT_BASE + 12'h004, 8'h03, "out bits");
    repeat (2) @(posedge clk);
    #1;
    `CHK("pin0 latch", latch[0], pin_out[0])
    `CHK("pin0 oe", dir[0], pin_oe_n[0])
    `CHK("pin1 periph", 1'b1, pin_out[1])
    `CHK("pin1 oe", 1'b0, pin_oe_n[1])
    `CHK("int in", EXT[15], p_in[0])
    `CHK("in1 route", EXT[5], p_in[1])
    @(posedge clk);
    unlock(8'h01);
    chk_rd(`PRL_LOCK_OFS, 8'h01, "lock set");
    `CHK("frozen", 1'b1, frozen)
    wr(`PRL_OUT_BASE + 12'h004, 8'h00);
    wr(`PRL_IN_BASE + 12'h004, 8'h07);
    chk_rd(`PRL_OUT_BASE + 12'h004, 8'h03, "out locked");
    chk_rd(`PRL_IN_BASE + 12'h004, 8'h05, "in locked");
    wr(`PRL_LOCK_OFS, `PRL_KEY1);
    wr(`PRL_IN_BASE, 8'h00);
    wr(`PRL_LOCK_OFS, `PRL_KEY2);
    wr(`PRL_LOCK_OFS, 8'h00);
    chk_rd(`PRL_LOCK_OFS, 8'h01, "abort");
    unlock(8'hfe);
    chk_rd(`PRL_LOCK_OFS, 8'h00, "lock clear");
    unlock(8'hff);
    chk_rd(`PRL_LOCK_OFS, 8'h01, "lock upper");
    sys_rstn <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rstn <= 1'b1;
    @(posedge clk);
    chk_rd(`PRL_LOCK_OFS, 8'h00, "sys lock");
    `CHK("sys frozen", 1'b0, frozen)
    chk_rd(`PRL_IN_BASE + 12'h004, 8'h05, "sys in");
    chk_rd(`PRL_OUT_BASE + 12'h004, 8'h03, "sys out");
    opt <= 1'b1;
    por();
    chk_rd(`PRL_IN_BASE + 12'h004, 8'h01, "por in");
    chk_rd(`PRL_OUT_BASE + 12'h004, 8'h00, "por out");
    chk_rd(`PRL_CFG_OFS, 8'h01, "option");
    unlock(8'h00);
    unlock(8'h01);
    unlock(8'h00);
    chk_rd(`PRL_LOCK_OFS, 8'h01, "one shot");
    `CHK("one shot frozen", 1'b1, frozen)
    complete_run();
  end
endmodule : prl_remap_top_tb
`default_nettype wire
